/* File: design/rssd_datapath.sv */
// rotate, subtract, set, swap and skip execution datapath
`timescale 1ns/1ps
`include "rssd_regs.svh"

// What this block does
// (RL1) rotate left via link, result to w
// (RL2) plain rotate right, memory or w form
// (RL3) rotate right via link, memory or w form, link changes
// (RL4) minus with borrow, six flags updated
// (RL5) minus with borrow from immediate too
// (RL6) link cleared on negative, set otherwise
// (RL7) plain minus, memory or immediate operand
// (RL8) decrement memory, skip when zero
// (RL9) decrement into w, skip when zero
// (RL10) increment memory, skip when zero
// (RL11) increment into w, skip when zero
// (RL12) taken skip inserts one dummy cycle
// (RL13) set all bits or one bit, no flags
// (RL14) skip when selected bit is nonzero
// (RL15) skip when whole byte is nonzero
// (RL16) skip when whole byte is zero
// (RL17) nibble exchange, memory or w form
// (RL18) eight-bit data; skip cancels next issue

module rssd_datapath
   import rssd_pkg::*;
(
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst,
   // instruction issue from the sequencer
   input  wire logic         issue_valid,
   input  wire rssd_issue_s  issue,
   // plain register port
   input  wire logic [7:0]   reg_addr,
   input  wire logic [7:0]   reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic [7:0]        reg_rdata,
   // data memory write side
   output rssd_mem_wr_s      mem_wr,
   // sequencer feedback
   output logic              skip_taken,
   output logic              issue_cancelled,
   // core state
   output logic [7:0]        w_value,
   output rssd_flags_s       flags
);

   // ****************************************************
   // state
   // ****************************************************

   logic [7:0]   w_q,       w_d;
   rssd_flags_s  flags_q,   flags_d;
   rssd_state_e  state_q,   state_d;
   rssd_mem_wr_s mem_wr_q,  mem_wr_d;
   logic         skip_q;
   logic         cancel_q;
   logic         skipped_q;
   logic [7:0]   rdata_q,   rdata_d;

   // ****************************************************
   // issue qualification
   // ****************************************************

   // an issue in the dummy cycle is the skipped instruction
   wire logic in_dummy  = (state_q == st_dummy);
   wire logic exec      = issue_valid & ~in_dummy;          // see (RL18)
   wire logic drop      = issue_valid & in_dummy;           // see (RL18)
   wire logic [7:0] opd = issue.mem_data;
   wire logic link      = flags_q.link_flag;

   // ****************************************************
   // subtraction unit
   // ****************************************************

   // operand select and borrow in
   wire logic use_imm = (issue.op == op_minus_with_borrow_imm) |
                        (issue.op == op_minus_imm);
   wire logic with_borrow = (issue.op == op_minus_with_borrow) |
                            (issue.op == op_minus_with_borrow_imm) |
                            (issue.op == op_minus_with_borrow_to_mem);
   wire logic [7:0] sub_b = use_imm ? issue.imm : opd;       // see (RL5)
   wire logic borrow_in   = with_borrow & ~link;             // see (RL4)

   // nine-bit difference and nibble difference
   wire logic [8:0] diff  = {1'b0, w_q} - {1'b0, sub_b} - {8'h00, borrow_in};
   wire logic [4:0] ndiff = {1'b0, w_q[3:0]} - {1'b0, sub_b[3:0]}
                          - {4'h0, borrow_in};
   wire logic [7:0] sub_r = diff[7:0];

   // flag values of a subtraction
   wire logic sub_link  = ~diff[8];                          // see (RL6)
   wire logic sub_half  = ~ndiff[4];
   wire logic sub_zero  = (sub_r == `RSSD_ZERO_BYTE);
   wire logic sub_ovf   = (w_q[7] ^ sub_b[7]) & (w_q[7] ^ sub_r[7]);
   wire logic sub_slink = ~(sub_ovf ^ sub_r[7]);
   wire logic sub_cnull = with_borrow ? (sub_zero & flags_q.chained_null_flag)
                                      : sub_zero;            // see (RL7)

   // ****************************************************
   // other result values
   // ****************************************************

   // rotates, counts, swaps and bit set
   wire logic [7:0] rl_link = {opd[6:0], link};               // see (RL1)
   wire logic [7:0] rr_pl   = {opd[0], opd[7:1]};             // see (RL2)
   wire logic [7:0] rr_link = {link, opd[7:1]};               // see (RL3)
   wire logic [7:0] dec_r   = opd - `RSSD_ONE_BYTE;
   wire logic [7:0] inc_r   = opd + `RSSD_ONE_BYTE;
   wire logic [7:0] swp_r   = {opd[3:0], opd[7:4]};           // see (RL17)
   wire logic [7:0] bit_msk = `RSSD_ONE_BYTE << issue.bit_idx;
   wire logic [7:0] setb_r  = opd | bit_msk;                  // see (RL13)
   wire logic       bit_nz  = |(opd & bit_msk);
   wire logic       opd_nz  = (opd != `RSSD_ZERO_BYTE);

   // ****************************************************
   // per-instruction decode
   // ****************************************************

   logic [7:0] res;
   logic       to_mem;
   logic       to_w;
   logic       arith;
   logic       link_upd;
   logic       link_new;
   logic       skip_cond;

   // result, destination and skip condition per code
   always_comb begin
      res       = opd;
      to_mem    = 1'b0;
      to_w      = 1'b0;
      arith     = 1'b0;
      link_upd  = 1'b0;
      link_new  = link;
      skip_cond = 1'b0;
      case (issue.op)
         op_rotate_left_via_link_to_w: begin
            res      = rl_link;
            to_w     = 1'b1;
            link_upd = 1'b1;
            link_new = opd[7];                               // see (RL1)
         end
         op_rotate_right_in_place: begin
            res    = rr_pl;
            to_mem = 1'b1;                                   // see (RL2)
         end
         op_rotate_right_to_w: begin
            res  = rr_pl;
            to_w = 1'b1;                                     // see (RL2)
         end
         op_rotate_right_via_link, op_rotate_right_via_link_to_w: begin
            res      = rr_link;
            to_mem   = (issue.op == op_rotate_right_via_link);
            to_w     = (issue.op == op_rotate_right_via_link_to_w);
            link_upd = 1'b1;
            link_new = opd[0];                               // see (RL3)
         end
         op_minus_with_borrow, op_minus_with_borrow_imm, op_minus_operand,
         op_minus_imm: begin
            res   = sub_r;
            to_w  = 1'b1;
            arith = 1'b1;                                    // see (RL4)
         end
         op_minus_with_borrow_to_mem, op_minus_operand_to_mem: begin
            res    = sub_r;
            to_mem = 1'b1;
            arith  = 1'b1;                                   // see (RL7)
         end
         op_decrement_skip_if_zero: begin
            res       = dec_r;
            to_mem    = 1'b1;
            skip_cond = (dec_r == `RSSD_ZERO_BYTE);          // see (RL8)
         end
         op_decrement_to_w_skip_if_zero: begin
            res       = dec_r;
            to_w      = 1'b1;
            skip_cond = (dec_r == `RSSD_ZERO_BYTE);          // see (RL9)
         end
         op_increment_skip_if_zero: begin
            res       = inc_r;
            to_mem    = 1'b1;
            skip_cond = (inc_r == `RSSD_ZERO_BYTE);          // see (RL10)
         end
         op_increment_to_w_skip_if_zero: begin
            res       = inc_r;
            to_w      = 1'b1;
            skip_cond = (inc_r == `RSSD_ZERO_BYTE);          // see (RL11)
         end
         op_set_all: begin
            res    = `RSSD_ALL_ONES;
            to_mem = 1'b1;                                   // see (RL13)
         end
         op_set_bit: begin
            res    = setb_r;
            to_mem = 1'b1;                                   // see (RL13)
         end
         op_skip_if_bit_nonzero: begin
            skip_cond = bit_nz;                              // see (RL14)
         end
         op_skip_if_nonzero: begin
            skip_cond = opd_nz;                              // see (RL15)
         end
         op_skip_if_zero_test: begin
            skip_cond = ~opd_nz;                             // see (RL16)
         end
         op_nibble_exchange: begin
            res    = swp_r;
            to_mem = 1'b1;                                   // see (RL17)
         end
         op_nibble_exchange_to_w: begin
            res  = swp_r;
            to_w = 1'b1;                                     // see (RL17)
         end
         default: begin
            res = opd;
         end
      endcase
   end

   // ****************************************************
   // register port decode
   // ****************************************************

   wire logic hit_w     = (reg_addr == `RSSD_OFF_WREG);
   wire logic hit_flags = (reg_addr == `RSSD_OFF_FLAGS);
   wire logic hit_stat  = (reg_addr == `RSSD_OFF_STATUS);
   wire logic sw_w      = reg_wr & hit_w;
   wire logic sw_flags  = reg_wr & hit_flags;

   // status byte and read mux, unmapped reads give zero
   wire logic [7:0] stat_byte = {6'h00, skipped_q, in_dummy};
   assign rdata_d = ~reg_rd   ? rdata_q :
                    hit_w     ? w_q :
                    hit_flags ? {2'b00, flags_q} :
                    hit_stat  ? stat_byte : `RSSD_ZERO_BYTE;

   // ****************************************************
   // next values
   // ****************************************************

   // an executing instruction wins over a software write
   wire logic take_skip = exec & skip_cond;                  // see (RL12)
   assign w_d = (exec & to_w) ? res :
                sw_w          ? reg_wdata : w_q;

   // flag update: full set, link only, or software write
   always_comb begin
      flags_d = flags_q;
      if (exec & arith) begin
         flags_d.link_flag                  = sub_link;      // see (RL6)
         flags_d.half_link_flag             = sub_half;
         flags_d.zero_flag                  = sub_zero;
         flags_d.signed_range_exceeded_flag = sub_ovf;
         flags_d.signed_link_flag           = sub_slink;
         flags_d.chained_null_flag          = sub_cnull;     // see (RL4)
      end else if (exec & link_upd) begin
         flags_d.link_flag = link_new;                       // see (RL3)
      end else if (sw_flags) begin
         flags_d = reg_wdata[5:0];
      end
   end

   // memory write request and sequencing state
   assign mem_wr_d = '{we: exec & to_mem, addr: issue.mem_addr, data: res};
   assign state_d  = take_skip ? st_dummy : st_exec;         // see (RL12)

   // ****************************************************
   // flip-flops
   // ****************************************************

   // core state registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         w_q     <= `RSSD_RST_WREG;
         flags_q <= `RSSD_RST_FLAGS;
         state_q <= st_exec;
      end else begin
         w_q     <= w_d;
         flags_q <= flags_d;
         state_q <= state_d;
      end
   end

   // output pulses and read data
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mem_wr_q  <= '0;
         skip_q    <= 1'b0;
         cancel_q  <= 1'b0;
         skipped_q <= 1'b0;
         rdata_q   <= `RSSD_ZERO_BYTE;
      end else begin
         mem_wr_q  <= mem_wr_d;
         skip_q    <= take_skip;
         cancel_q  <= drop;                                  // see (RL18)
         skipped_q <= exec ? take_skip : skipped_q;
         rdata_q   <= rdata_d;
      end
   end

   // ****************************************************
   // outputs
   // ****************************************************

   assign reg_rdata       = rdata_q;
   assign mem_wr          = mem_wr_q;
   assign skip_taken      = skip_q;
   assign issue_cancelled = cancel_q;
   assign w_value         = w_q;
   assign flags           = flags_q;

endmodule // rssd_datapath

/* File: design/rssd_regs.svh */
// constants of the rotate, subtract and skip datapath
`ifndef RSSD_REGS_SVH
`define RSSD_REGS_SVH

// data width of every operand
`define RSSD_DATA_W       8

// register offsets on the plain register port
`define RSSD_OFF_WREG     8'h00
`define RSSD_OFF_FLAGS    8'h04
`define RSSD_OFF_STATUS   8'h08

// bit positions in the flag register
`define RSSD_FLAG_LINK    0
`define RSSD_FLAG_HALF    1
`define RSSD_FLAG_ZERO    2
`define RSSD_FLAG_OVF     3
`define RSSD_FLAG_SLINK   4
`define RSSD_FLAG_CNULL   5

// bit positions in the status register
`define RSSD_STAT_DUMMY   0
`define RSSD_STAT_SKIPPED 1

// reset values
`define RSSD_RST_WREG     8'h00
`define RSSD_RST_FLAGS    6'h00

// constant bytes
`define RSSD_ALL_ONES     8'hff
`define RSSD_ZERO_BYTE    8'h00
`define RSSD_ONE_BYTE     8'h01

`endif

/* File: design/rssd_pkg.sv */
// types of the rotate, subtract and skip datapath
package rssd_pkg;

   // instruction codes handled by the datapath
   typedef enum logic [4:0] {
      op_nop,
      op_rotate_left_via_link_to_w,
      op_rotate_right_in_place,
      op_rotate_right_to_w,
      op_rotate_right_via_link,
      op_rotate_right_via_link_to_w,
      op_minus_with_borrow,
      op_minus_with_borrow_imm,
      op_minus_with_borrow_to_mem,
      op_minus_operand,
      op_minus_imm,
      op_minus_operand_to_mem,
      op_decrement_skip_if_zero,
      op_decrement_to_w_skip_if_zero,
      op_increment_skip_if_zero,
      op_increment_to_w_skip_if_zero,
      op_set_all,
      op_set_bit,
      op_skip_if_bit_nonzero,
      op_skip_if_nonzero,
      op_skip_if_zero_test,
      op_nibble_exchange,
      op_nibble_exchange_to_w
   } rssd_op_e;

   // one issued instruction with its fetched operand
   typedef struct packed {
      rssd_op_e   op;
      logic [7:0] mem_addr;
      logic [7:0] mem_data;
      logic [7:0] imm;
      logic [2:0] bit_idx;
   } rssd_issue_s;

   // write request toward data memory
   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] data;
   } rssd_mem_wr_s;

   // arithmetic flags
   typedef struct packed {
      logic chained_null_flag;
      logic signed_link_flag;
      logic signed_range_exceeded_flag;
      logic zero_flag;
      logic half_link_flag;
      logic link_flag;
   } rssd_flags_s;

   // sequencing state
   typedef enum logic {
      st_exec,
      st_dummy
   } rssd_state_e;

endpackage

/* File: tb/rssd_mem_model.sv */
// data memory model behind the datapath
`timescale 1ns/1ps
module rssd_mem_model
   import rssd_pkg::*;
(
   // clock
   input  wire logic         ref_clk,
   // write side from the datapath
   input  wire rssd_mem_wr_s mem_wr,
   // operand read for the sequencer
   input  wire logic [7:0]   rd_addr,
   output logic [7:0]        rd_data
);
   logic [7:0] mem [256];
   // each byte starts as its own address
   initial for (int i = 0; i < 256; i++) mem[i] = i[7:0];
   // byte writes land one edge after the request
   always @(posedge ref_clk) if (mem_wr.we) mem[mem_wr.addr] <= mem_wr.data;
   assign rd_data = mem[rd_addr];
endmodule // rssd_mem_model

/* File: tb/rssd_datapath_chk.sv */
// concurrent checks on the datapath ports
`timescale 1ns/1ps
module rssd_datapath_chk
   import rssd_pkg::*;
(
   // clock and reset
   input wire logic         ref_clk,
   input wire logic         rst,
   // issue side
   input wire logic         issue_valid,
   input wire rssd_issue_s  issue,
   // software write strobe
   input wire logic         reg_wr,
   // results
   input wire rssd_mem_wr_s mem_wr,
   input wire logic         skip_taken,
   input wire logic         issue_cancelled,
   input wire logic [7:0]   w_value,
   input wire rssd_flags_s  flags
);
   // ****************
   // issue acceptance
   // ****************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // skip_taken high marks the dummy cycle
   wire logic take = issue_valid & ~skip_taken & ~reg_wr;   // no software write beside it
   // a taken skip is never followed by another
   chk_skip_pulse: assert property (skip_taken |=> !skip_taken)
      else $error("skip pulse too long");
   chk_dec_skip: assert property (take && issue.op == op_decrement_skip_if_zero |=>
      mem_wr.we && mem_wr.data == $past(issue.mem_data) - 8'h01
      && skip_taken == ($past(issue.mem_data) == 8'h01)) else $error("decrement skip wrong");
   chk_inc_to_w: assert property (take && issue.op == op_increment_to_w_skip_if_zero
      |=> w_value == $past(issue.mem_data) + 8'h01 && !mem_wr.we && flags == $past(flags))
      else $error("increment to w wrong");
   chk_rot_to_w: assert property (take && issue.op == op_rotate_right_to_w |=>
      w_value == {$past(issue.mem_data[0]), $past(issue.mem_data[7:1])} && !mem_wr.we)
      else $error("rotate right to w wrong");
   chk_set_all: assert property (take && issue.op == op_set_all |=> mem_wr.we
      && mem_wr.data == 8'hff && mem_wr.addr == $past(issue.mem_addr)) else $error("set all wrong");
   chk_sub_link: assert property (take && issue.op == op_minus_operand |=>
      flags.link_flag == ($past(w_value) >= $past(issue.mem_data))) else $error("link wrong");
   chk_nonzero_skip: assert property (take && issue.op == op_skip_if_nonzero |=>
      skip_taken == (|$past(issue.mem_data)) && !mem_wr.we) else $error("nonzero skip wrong");
   chk_dummy_cancel: assert property (issue_valid && skip_taken && !reg_wr |=>
      issue_cancelled && !mem_wr.we && $stable(w_value)) else $error("dummy issue not dropped");
   cov_skip: cover property (skip_taken);
   cov_cancel: cover property (issue_cancelled);
   cov_borrow: cover property (take && issue.op == op_minus_with_borrow ##1 !flags.link_flag);
endmodule // rssd_datapath_chk
bind rssd_datapath rssd_datapath_chk chk_u (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr),
   .issue_valid(issue_valid), .issue(issue), .mem_wr(mem_wr), .skip_taken(skip_taken),
   .issue_cancelled(issue_cancelled), .w_value(w_value), .flags(flags));

/* File: tb/rssd_datapath_tb_top.sv */
// self-checking bench of the rotate, subtract and skip datapath
`timescale 1ns/1ps
module rssd_datapath_tb_top import rssd_pkg::*; ;
   // *******************
   // signals and models
   // *******************
   logic ref_clk = 1'b0, rst = 1'b1, issue_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   rssd_op_e     iss_op = op_nop;
   logic [7:0]   iss_addr = 8'h00, iss_imm = 8'h00, reg_addr = 8'h00, reg_wdata = 8'h00;
   logic [2:0]   iss_bit = 3'h0;
   logic [7:0]   rd_data, reg_rdata, w_value, ew, ewd, ewa, erd, m, nv, bsel;
   logic         skip_taken, issue_cancelled, ewe, esk, ecan, edum, erp, wm, sk, chn, eskd;
   rssd_issue_s  issue;
   rssd_mem_wr_s mem_wr;
   rssd_flags_s  flags, efl;
   logic [13:0]  s;
   logic [31:0]  rng = 32'hff88;
   logic [31:0]  r;
   int           num_errors = 0, compares = 0;
   logic [7:0]   reg_tab [4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
   rssd_datapath dut_u (.ref_clk(ref_clk), .rst(rst), .issue_valid(issue_valid), .issue(issue),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .mem_wr(mem_wr), .skip_taken(skip_taken),
      .issue_cancelled(issue_cancelled), .w_value(w_value), .flags(flags));
   rssd_mem_model mem_u (.ref_clk(ref_clk), .mem_wr(mem_wr), .rd_addr(iss_addr),
      .rd_data(rd_data));
   // operand always comes fresh from the memory model
   assign issue = {iss_op, iss_addr, rd_data, iss_imm, iss_bit};
   always #10 ref_clk = ~ref_clk;
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   // flags and result of a subtraction with borrow in
   function automatic logic [13:0] sub_calc(input logic [7:0] a, b, input logic bin, cn, ch);
      logic [8:0] d;
      logic [4:0] h;
      logic       ov;
      d = {1'b0, a} - {1'b0, b} - {8'h00, bin};
      h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
      ov = (a[7] != b[7]) && (d[7] != a[7]);
      return {(d[7:0] == 8'h00) & (cn | !ch), !(ov ^ d[7]), ov, d[7:0] == 8'h00, !h[4], !d[8],
         d[7:0]};
   endfunction
   task automatic check_byte(input logic [7:0] got, exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t: byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t: bit %b expected %b", $time, got, exp);
      end
   endtask
   // ******************
   // reference model
   // ******************
   always @(posedge ref_clk) begin
      if (rst) begin
         {ew, efl, ewe, esk, ecan, edum, erp, eskd} = 20'h00000;
      end else begin
         check_byte(w_value, ew);
         check_byte({2'b00, flags}, {2'b00, efl});
         check_bit(mem_wr.we, ewe);
         if (ewe) begin
            check_byte(mem_wr.data, ewd);
            check_byte(mem_wr.addr, ewa);
         end
         check_bit(skip_taken, esk);
         check_bit(issue_cancelled, ecan);
         if (erp) check_byte(reg_rdata, erd);
         erp = reg_rd;
         // status byte holds last skip outcome and the dummy cycle
         erd = reg_addr == 8'h00 ? ew : reg_addr == 8'h04 ? {2'b00, efl} :
            reg_addr == 8'h08 ? {6'h00, eskd, edum} : 8'h00;
         if (reg_wr && reg_addr == 8'h00) ew = reg_wdata;
         if (reg_wr && reg_addr == 8'h04) efl = reg_wdata[5:0];
         {m, wm, sk, nv} = {issue.mem_data, 10'h000};
         ecan = issue_valid && edum;
         if (issue_valid && !edum) begin
            chn = issue.op inside {op_minus_with_borrow, op_minus_with_borrow_imm,
               op_minus_with_borrow_to_mem};
            bsel = issue.op inside {op_minus_with_borrow_imm, op_minus_imm} ? issue.imm : m;
            s = sub_calc(ew, bsel, chn & !efl.link_flag, efl.chained_null_flag, chn);
            case (issue.op)
               op_rotate_left_via_link_to_w: {ew, efl.link_flag} = {m[6:0], efl.link_flag, m[7]};
               op_rotate_right_in_place: {wm, nv} = {1'b1, m[0], m[7:1]};
               op_rotate_right_to_w: ew = {m[0], m[7:1]};
               op_rotate_right_via_link: {wm, nv, efl.link_flag} = {1'b1, efl.link_flag, m};
               op_rotate_right_via_link_to_w: {ew, efl.link_flag} = {efl.link_flag, m};
               op_minus_with_borrow_to_mem, op_minus_operand_to_mem:
                  {efl, wm, nv} = {s[13:8], 1'b1, s[7:0]};
               op_minus_with_borrow, op_minus_with_borrow_imm, op_minus_operand, op_minus_imm:
                  {efl, ew} = s;
               op_decrement_skip_if_zero: {wm, nv, sk} = {1'b1, m - 8'h01, m == 8'h01};
               op_decrement_to_w_skip_if_zero: {ew, sk} = {m - 8'h01, m == 8'h01};
               op_increment_skip_if_zero: {wm, nv, sk} = {1'b1, m + 8'h01, m == 8'hff};
               op_increment_to_w_skip_if_zero: {ew, sk} = {m + 8'h01, m == 8'hff};
               op_set_all: {wm, nv} = {1'b1, 8'hff};
               op_set_bit: {wm, nv} = {1'b1, m | (8'h01 << issue.bit_idx)};
               op_skip_if_bit_nonzero: sk = m[issue.bit_idx];
               op_skip_if_nonzero: sk = m != 8'h00;
               op_skip_if_zero_test: sk = m == 8'h00;
               op_nibble_exchange: {wm, nv} = {1'b1, m[3:0], m[7:4]};
               op_nibble_exchange_to_w: ew = {m[3:0], m[7:4]};
               default: ;
            endcase
            eskd = sk;
         end
         {ewe, ewd, ewa, esk, edum} = {wm, nv, issue.mem_addr, sk, sk};
      end
   end
   // ******************
   // stimulus
   // ******************
   task automatic issue_op(input rssd_op_e o, input logic [7:0] a, im, input logic [2:0] b);
      @(posedge ref_clk);
      {issue_valid, reg_wr, reg_rd} <= 3'b100;
      iss_op <= o;
      {iss_addr, iss_imm, iss_bit} <= {a, im, b};
   endtask
   task automatic reg_access(input logic wr, input logic [7:0] a, d);
      @(posedge ref_clk);
      {issue_valid, reg_wr, reg_rd, reg_addr, reg_wdata} <= {1'b0, wr, !wr, a, d};
   endtask
   task automatic idle();
      @(posedge ref_clk);
      {issue_valid, reg_wr, reg_rd} <= 3'b000;
   endtask
   task automatic complete_run();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #(20 * 20000);
      num_errors++;
      $display("Error %0t: watchdog expired", $time);
      complete_run();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 23; i++) issue_op(rssd_op_e'(i), 8'(i * 11), 8'(i * 7), 3'(i));
      // skips followed at once by an issue that must drop
      issue_op(op_decrement_skip_if_zero, 8'h01, 8'h00, 3'h0);
      issue_op(op_set_all, 8'h05, 8'h00, 3'h0);
      issue_op(op_increment_skip_if_zero, 8'hff, 8'h00, 3'h0);
      issue_op(op_skip_if_zero_test, 8'h01, 8'h00, 3'h0);
      reg_access(1'b1, 8'h04, 8'h00);
      issue_op(op_minus_with_borrow_imm, 8'h00, 8'h00, 3'h0);
      reg_access(1'b0, 8'h04, 8'h00);
      reg_access(1'b0, 8'h0c, 8'h00);
      // status read in the dummy cycle, then once more after it
      issue_op(op_skip_if_nonzero, 8'h02, 8'h00, 3'h0);
      reg_access(1'b0, 8'h08, 8'h00);
      reg_access(1'b0, 8'h08, 8'h00);
      idle();
      $display("directed test done");
      repeat (3000) begin
         r = xs(rng);
         rng = r;
         if (r[1]) issue_op(rssd_op_e'(5'(r[8:4] % 5'd23)), r[23:16], r[31:24], r[11:9]);
         else if (r[0]) reg_access(r[12], reg_tab[r[14:13]], r[31:24]);
         else idle();
      end
      idle();
      idle();
      $display("random test done");
      complete_run();
   end
endmodule // rssd_datapath_tb_top
